// >>> pin_scan_defines.vh
// Register offsets, field positions and reset values of the pin and scan configuration bank
`ifndef PIN_SCAN_DEFINES_VH
`define PIN_SCAN_DEFINES_VH

`define ADDR_PIN_FUNCTION 8'h05
`define ADDR_PIN_DIRECTION 8'h07
`define ADDR_OUTPUT_DRIVE_TYPE 8'h09
`define ADDR_OUTPUT_LEVEL 8'h0b
`define ADDR_INPUT_LEVEL 8'h0d
`define ADDR_SCAN_CONTROL 8'h10
`define ADDR_MANUAL_CHANNEL 8'h11
`define ADDR_SCAN_ENABLE_MASK 8'h12

`define SCAN_MODE_LSB 0
`define SCAN_MODE_MSB 1
`define SCAN_RUN_BIT 4
`define CHID_LSB 0
`define CHID_MSB 3

`define SCAN_MODE_MANUAL 2'h0
`define SCAN_MODE_AUTO 2'h1

`define SCAN_CONTROL_WMASK 8'h13
`define MANUAL_CHANNEL_WMASK 8'h0f
`define REG_RESET 8'h00

`define SCAN_DWELL_CYCLES 8'h10

`endif

// >>> pin_sync.v
// Two-flop synchroniser bank for the general-purpose pin inputs
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter WIDTH = 8
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] stable_q;

    // First stage feeds only the second stage
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_q <= {WIDTH{1'b0}};
            stable_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_i;
            stable_q <= meta_q;
        end
    end

    assign sync_o = stable_q;

endmodule // pin_sync

`default_nettype wire

// >>> scan_sequencer.v
// Automatic channel sequencer stepping through enabled analog channels in ascending order
`timescale 1ns/100ps
`default_nettype none

module scan_sequencer #(
    parameter CHANNELS = 8,
    parameter DWELL = 16
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire run_i,
    input wire [CHANNELS-1:0] enable_i,
    output reg [2:0] channel_o,
    output reg active_o
);

    // Last dwell count, kept as a full integer so the compare is not cut
    localparam integer DWELL_LAST = DWELL - 1;

    reg [7:0] dwell_q;
    reg [2:0] next_ch;
    reg found;
    reg [31:0] idx;
    integer k;

    // Next enabled channel above the current one, wrapping to the lowest
    always @* begin
        next_ch = channel_o;
        found = 1'b0;
        idx = 32'h0;
        for (k = 2 * CHANNELS - 1; k > 0; k = k - 1) begin
            idx = (channel_o + k) % CHANNELS;
            if (enable_i[idx]) begin
                next_ch = idx[2:0];
                found = 1'b1;
            end
        end
        if (!found && enable_i[channel_o]) begin
            found = 1'b1;
        end
    end

    // Channel stays for a dwell period, then moves on
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            channel_o <= 3'h0;
            active_o <= 1'b0;
            dwell_q <= 8'h00;
        end else if (!run_i || enable_i == {CHANNELS{1'b0}}) begin
            active_o <= 1'b0;
            dwell_q <= 8'h00;
        end else if (!active_o) begin
            active_o <= 1'b1;
            dwell_q <= 8'h00;
            if (!enable_i[channel_o]) begin
                channel_o <= next_ch;
            end
        end else if ({24'h0, dwell_q} == DWELL_LAST) begin
            dwell_q <= 8'h00;
            channel_o <= found ? next_ch : channel_o;
        end else begin
            dwell_q <= dwell_q + 8'h01;
        end
    end

endmodule // scan_sequencer

`default_nettype wire

// >>> pin_io_and_scan_config_regs.v
// Pin input/output and channel scan configuration registers with pin drivers
`timescale 1ns/100ps
`default_nettype none
`include "pin_scan_defines.vh"

// Contract
// - Direction bit 0 makes pin an input, 1 makes it an output.
// - Drive type bit 0 selects open-drain, 1 selects push-pull.
// - Output level bit sets driven logic level, 0 low, 1 high.
// - Input level register returns synchronised level of each pin.
// - Scan mode 00 manual, 01 automatic, 10 and 11 reserved.
// - In automatic mode scan run 1 starts ascending sequencing, 0 stops.
// - Manual mode channel id 0..7 selects input; 8 and above reserved.
// - Reserved bits of scan and manual channel registers read zero.
// - Function bit 0 analog, 1 pin; pin settings apply only when set.
// - Scan enable mask includes channel with 1, skips it with 0.
module pin_io_and_scan_config_regs #(
    parameter CHANNELS = 8,
    parameter DWELL = 16
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    input wire [CHANNELS-1:0] pin_i,
    output reg [CHANNELS-1:0] pin_o,
    output reg [CHANNELS-1:0] pin_oe_o,
    output reg [2:0] conv_channel_o,
    output reg conv_channel_valid_o,
    output reg scan_active_o
);

    reg [7:0] pin_function_q;
    reg [7:0] pin_direction_q;
    reg [7:0] output_drive_type_select_q;
    reg [7:0] output_level_set_q;
    reg [1:0] scan_mode_select_q;
    reg scan_run_q;
    reg [3:0] fixed_channel_id_q;
    reg [7:0] scan_channel_enable_mask_q;
    reg [7:0] rdata_d;
    reg [CHANNELS-1:0] pin_d;
    reg [CHANNELS-1:0] oe_d;
    reg [2:0] conv_ch_d;
    reg conv_valid_d;
    wire [CHANNELS-1:0] input_level_readback;
    wire [2:0] seq_channel;
    wire seq_active;
    wire auto_run;
    genvar g;

    pin_sync #(
        .WIDTH(CHANNELS)
    ) u_pin_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(pin_i),
        .sync_o(input_level_readback)
    );

    // Sequencer runs only in automatic mode with run set
    assign auto_run = (scan_mode_select_q == `SCAN_MODE_AUTO) && scan_run_q;

    scan_sequencer #(
        .CHANNELS(CHANNELS),
        .DWELL(DWELL)
    ) u_scan_sequencer (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(auto_run),
        .enable_i(scan_channel_enable_mask_q & ~pin_function_q),
        .channel_o(seq_channel),
        .active_o(seq_active)
    );

    // Register writes; reserved bits masked off
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_function_q <= `REG_RESET;
            pin_direction_q <= `REG_RESET;
            output_drive_type_select_q <= `REG_RESET;
            output_level_set_q <= `REG_RESET;
            scan_mode_select_q <= 2'h0;
            scan_run_q <= 1'b0;
            fixed_channel_id_q <= 4'h0;
            scan_channel_enable_mask_q <= `REG_RESET;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `ADDR_PIN_FUNCTION: begin
                    pin_function_q <= reg_wdata_i;
                end
                `ADDR_PIN_DIRECTION: begin
                    pin_direction_q <= reg_wdata_i;
                end
                `ADDR_OUTPUT_DRIVE_TYPE: begin
                    output_drive_type_select_q <= reg_wdata_i;
                end
                `ADDR_OUTPUT_LEVEL: begin
                    output_level_set_q <= reg_wdata_i;
                end
                `ADDR_SCAN_CONTROL: begin
                    scan_mode_select_q <= reg_wdata_i[`SCAN_MODE_MSB:`SCAN_MODE_LSB];
                    scan_run_q <= reg_wdata_i[`SCAN_RUN_BIT];
                end
                `ADDR_MANUAL_CHANNEL: begin
                    fixed_channel_id_q <= reg_wdata_i[`CHID_MSB:`CHID_LSB];
                end
                `ADDR_SCAN_ENABLE_MASK: begin
                    scan_channel_enable_mask_q <= reg_wdata_i;
                end
                default: begin
                    pin_function_q <= pin_function_q;
                end
            endcase
        end
    end

    // Read mux; reserved bits and unmapped offsets read zero
    always @* begin
        rdata_d = reg_rdata_o;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `ADDR_PIN_FUNCTION: rdata_d = pin_function_q;
                `ADDR_PIN_DIRECTION: rdata_d = pin_direction_q;
                `ADDR_OUTPUT_DRIVE_TYPE: rdata_d = output_drive_type_select_q;
                `ADDR_OUTPUT_LEVEL: rdata_d = output_level_set_q;
                `ADDR_INPUT_LEVEL: rdata_d = input_level_readback;
                `ADDR_SCAN_CONTROL: rdata_d = {3'h0, scan_run_q, 2'h0, scan_mode_select_q};
                `ADDR_MANUAL_CHANNEL: rdata_d = {4'h0, fixed_channel_id_q};
                `ADDR_SCAN_ENABLE_MASK: rdata_d = scan_channel_enable_mask_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // Per-pin driver: pin function gates the output enable; pin_o follows the level setting
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : g_pin
            always @* begin
                pin_d[g] = output_level_set_q[g];
                oe_d[g] = 1'b0;
                if (pin_function_q[g] && pin_direction_q[g]) begin
                    // Open-drain drives only low; push-pull drives both levels
                    oe_d[g] = output_drive_type_select_q[g] | ~output_level_set_q[g];
                end
            end
        end
    endgenerate

    // Channel for next conversion from manual id or sequencer
    always @* begin
        conv_ch_d = 3'h0;
        conv_valid_d = 1'b0;
        case (scan_mode_select_q)
            `SCAN_MODE_MANUAL: begin
                conv_ch_d = fixed_channel_id_q[2:0];
                // Pin-configured channel gives no valid result
                conv_valid_d = ~fixed_channel_id_q[3] & ~pin_function_q[fixed_channel_id_q[2:0]];
            end
            `SCAN_MODE_AUTO: begin
                conv_ch_d = seq_channel;
                conv_valid_d = seq_active;
            end
            default: begin
                conv_valid_d = 1'b0;
            end
        endcase
    end

    // Registered outputs
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
            pin_o <= {CHANNELS{1'b0}};
            pin_oe_o <= {CHANNELS{1'b0}};
            conv_channel_o <= 3'h0;
            conv_channel_valid_o <= 1'b0;
            scan_active_o <= 1'b0;
        end else begin
            reg_rdata_o <= rdata_d;
            pin_o <= pin_d;
            pin_oe_o <= oe_d;
            conv_channel_o <= conv_ch_d;
            conv_channel_valid_o <= conv_valid_d;
            scan_active_o <= seq_active;
        end
    end

endmodule // pin_io_and_scan_config_regs

`default_nettype wire

// >>> pin_pad_model.sv
// Pad model: outside drivers and pull-ups seen by the pins
`timescale 1ns/100ps
`default_nettype none
module pin_pad_model (
    input wire logic [7:0] pin_o_i,
    input wire logic [7:0] pin_oe_i,
    input wire logic [7:0] ext_i,
    input wire logic [7:0] ext_en_i,
    output logic [7:0] level_o
);
    // Device drive wins, then the outside driver, else the pull-up
    always_comb begin
        level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_en_i & ext_i);
        level_o = level_o | (~pin_oe_i & ~ext_en_i);
    end
endmodule // pin_pad_model
`default_nettype wire

// >>> pin_io_chk.sv
// Port checker for the pin and scan register bank
`timescale 1ns/100ps
`default_nettype none
module pin_io_chk (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_o,
    input wire logic scan_active_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Accesses to one offset
    sequence wr_at(a); reg_wr_i && reg_addr_i == a; endsequence
    sequence rd_at(a); reg_rd_i && reg_addr_i == a; endsequence
    chk_level_drive: assert property (wr_at(8'h0b) |-> ##2 pin_o == $past(reg_wdata_i, 2))
        else $error("pin level differs from written level");
    chk_dir_input: assert property (wr_at(8'h07) ##0 reg_wdata_i == 8'h00 |-> ##2 !pin_oe_o)
        else $error("input pin still driven");
    chk_func_analog: assert property (wr_at(8'h05) ##0 reg_wdata_i == 8'h00 |-> ##2 !pin_oe_o)
        else $error("analog channel still driven");
    chk_scan_rsvd: assert property (rd_at(8'h10) |=> (reg_rdata_o & 8'hec) == 8'h00)
        else $error("scan control spare bits set");
    chk_chan_rsvd: assert property (rd_at(8'h11) |=> reg_rdata_o[7:4] == 4'h0)
        else $error("channel select spare bits set");
    chk_unmapped_read: assert property (rd_at(8'h00) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    chk_scan_stop: assert property (wr_at(8'h10) ##0 !reg_wdata_i[4] |-> ##[1:4] !scan_active_o)
        else $error("scan kept running after stop");
endmodule // pin_io_chk
bind pin_io_and_scan_config_regs pin_io_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .scan_active_o(scan_active_o));
`default_nettype wire

// >>> pin_io_and_scan_config_regs_tb.sv
// Testbench for the pin and scan register bank
`timescale 1ns/100ps
`default_nettype none
module pin_io_and_scan_config_regs_tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wd = 8'h00;
    logic [7:0] ext = 8'h00;
    logic [7:0] ext_en = 8'h00;
    wire [7:0] rdat;
    wire [7:0] pin_i;
    wire [7:0] pin_o;
    wire [7:0] oe;
    wire [2:0] ch;
    wire ch_ok;
    wire act;
    int mismatches = 0;
    int n_compared = 0;
    pin_io_and_scan_config_regs #(.CHANNELS(8), .DWELL(2)) dut (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wd), .reg_rdata_o(rdat), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(oe),
        .conv_channel_o(ch), .conv_channel_valid_o(ch_ok), .scan_active_o(act));
    pin_pad_model pads (.pin_o_i(pin_o), .pin_oe_i(oe), .ext_i(ext), .ext_en_i(ext_en),
        .level_o(pin_i));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // One-cycle write strobe
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        idle(1);
        {wr, addr, wd} = {1'b1, a, d};
        idle(1);
        wr = 1'b0;
    endtask
    // One-cycle read strobe, data compared after the taking edge
    task automatic r(input logic [7:0] a, input logic [7:0] exp);
        idle(1);
        {rd, addr} = {1'b1, a};
        idle(1);
        rd = 1'b0;
        chk(rdat, exp);
    endtask
    task automatic wait_ch(input logic [2:0] c);
        for (int k = 0; k < 64 && ch !== c; k++) idle(1);
        chk({5'h0, ch}, {5'h0, c});
        if (ch !== c) finish_test();
    endtask
    // Mid-run reset clears written registers
    task automatic t_reset();
        w(8'h07, 8'hff);
        w(8'h11, 8'h05);
        idle(1);
        sys_rst_i = 1'b1;
        idle(2);
        sys_rst_i = 1'b0;
        r(8'h07, 8'h00);
        r(8'h11, 8'h00);
        r(8'h10, 8'h00);
    endtask
    task automatic t_access();
        logic [7:0] offs[3] = '{8'h07, 8'h09, 8'h0b};
        foreach (offs[i]) r(offs[i], 8'h00);
        r(8'h10, 8'h00);
        r(8'h11, 8'h00);
        foreach (offs[i]) w(offs[i], 8'ha5);
        foreach (offs[i]) r(offs[i], 8'ha5);
        w(8'h10, 8'hee);
        r(8'h10, 8'h02);
        w(8'h11, 8'hff);
        r(8'h11, 8'h0f);
        r(8'h00, 8'h00);
    endtask
    // Drive enables for push-pull, open-drain low and open-drain high
    task automatic t_pins();
        {ext_en, ext} = {8'hf0, 8'h30};
        w(8'h05, 8'hff);
        w(8'h07, 8'h0f);
        w(8'h09, 8'h05);
        w(8'h0b, 8'h03);
        idle(4);
        chk(oe, 8'h0d);
        r(8'h0d, 8'h33);
        w(8'h09, 8'h00);
        w(8'h0b, 8'h0f);
        idle(4);
        chk(oe, 8'h00);
        r(8'h0d, 8'h3f);
        w(8'h0b, 8'h00);
        idle(2);
        chk(oe, 8'h0f);
        w(8'h05, 8'h00);
        idle(2);
        chk(oe, 8'h00);
    endtask
    task automatic t_manual();
        w(8'h05, 8'h04);
        w(8'h10, 8'h00);
        w(8'h11, 8'h03);
        idle(2);
        chk({ch_ok, 4'h0, ch}, 8'h83);
        w(8'h11, 8'h02);
        idle(2);
        chk({7'h0, ch_ok}, 8'h00);
        w(8'h11, 8'h08);
        idle(2);
        chk({7'h0, ch_ok}, 8'h00);
        w(8'h11, 8'h03);
        w(8'h10, 8'h02);
        idle(2);
        chk({7'h0, ch_ok}, 8'h00);
    endtask
    // Mask with channels 1 and 5, channel 1 then taken as a pin
    task automatic t_auto();
        w(8'h05, 8'h00);
        w(8'h12, 8'h22);
        w(8'h10, 8'h11);
        wait_ch(3'h1);
        chk({7'h0, act}, 8'h01);
        wait_ch(3'h5);
        wait_ch(3'h1);
        w(8'h05, 8'h02);
        idle(12);
        chk({4'h0, ch_ok, ch}, 8'h0d);
        w(8'h10, 8'h01);
        idle(4);
        chk({7'h0, act}, 8'h00);
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        idle(20);
        sys_rst_i = 1'b0;
        t_access();
        t_pins();
        t_manual();
        t_auto();
        t_reset();
        finish_test();
    end
endmodule // pin_io_and_scan_config_regs_tb
`default_nettype wire
